// ===== adc_link_pkg.sv
package adc_link_pkg;
  // frame shape
  localparam int FRAME_EDGES    = 16;
  localparam int LEAD_ZEROS     = 4;
  localparam int RESULT_BITS    = 12;
  localparam int HOLD_EDGES     = 13;
  localparam int PD_LOW_EDGES   = 2;
  localparam int STAY_UP_EDGES  = 10;
  localparam int CNT_W          = 5;
  // timing
  localparam int CLK_PERIOD_NS  = 100;
  localparam int POWER_UP_NS    = 1000;
  localparam int QUIET_NS       = 25;
  localparam int ACQ_NS         = 200;
  localparam int RELEASE_NS     = 35;
  localparam int POWER_UP_CYC   =
    (POWER_UP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int QUIET_CYC      =
    (QUIET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACQ_CYC        =
    (ACQ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RELEASE_CYC    =
    (RELEASE_NS / CLK_PERIOD_NS) < 1 ? 1 : RELEASE_NS / CLK_PERIOD_NS;
  localparam int SCLK_HALF      = 4;
  localparam int TIMER_W        = 8;
endpackage : adc_link_pkg

// ===== adc_link_if.sv
`timescale 1ns/10ps
`default_nettype none
interface adc_link_if;
  logic sel_n;
  logic sclk;
  logic sdo_o;
  logic sdo_oe;
  logic sdo;
  assign sdo = sdo_oe ? sdo_o : 1'b1;
  modport device (input sel_n, input sclk, output sdo_o, output sdo_oe);
  modport host (output sel_n, output sclk, input sdo);
endinterface : adc_link_if
`default_nettype wire

// ===== adc_device_end.sv
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - select falling: hold, sample, drive output
// - select presents zero; falling edges shift
// - release output at sixteenth falling edge
// - back to track after thirteenth edge
// - host leaves 200 ns acquisition
// - host leaves 25 ns quiet time
// - select low ten edges keeps powered
// - rise after tenth edge aborts, stays up
// - sixteen clocks complete conversion and readout
// - host waits quiet time after release
// - rise between second and tenth: power down
// - power-down aborts, output floats quickly
// - rise before second edge: stay normal
// - dummy frame past tenth edge wakes
// - short frame while down: stay down
// - one dummy frame always enough
// - host keeps quiet time after dummy
// - waking: track on first clock edge
// - host may end dummy after tenth edge
// - host forces mode after supply up
// - host may dummy at once after power
// - at power-on, track already on
module adc_device_end
  import adc_link_pkg::*;
#(
  parameter int POWER_UP_CYCLES = POWER_UP_CYC
) (
  // clock and reset
  input  wire logic                   CLK,
  input  wire logic                   SYS_RST,
  // link
  adc_link_if.device                  LINK,
  // user side
  input  wire logic [RESULT_BITS-1:0] SAMPLE_IN,
  output logic      [RESULT_BITS-1:0] SAMPLE_HELD,
  output logic                        TRACKING,
  output logic                        POWERED_DOWN,
  output logic                        POWERED_UP
);
  // pin synchronisers and edge history
  logic                   sel_s1_reg;
  logic                   sel_s2_reg;
  logic                   sel_d_reg;
  logic                   clk_s1_reg;
  logic                   clk_s2_reg;
  logic                   clk_d_reg;
  // frame and power state
  logic                   active_reg;
  logic                   active_next;
  logic [CNT_W-1:0]       cnt_reg;
  logic [CNT_W-1:0]       cnt_next;
  logic [FRAME_EDGES-1:0] shift_reg;
  logic [FRAME_EDGES-1:0] shift_next;
  logic                   oe_reg;
  logic                   oe_next;
  logic                   track_reg;
  logic                   track_next;
  logic                   pd_reg;
  logic                   pd_next;
  logic                   waking_reg;
  logic                   waking_next;
  logic [RESULT_BITS-1:0] held_reg;
  logic [RESULT_BITS-1:0] held_next;
  logic [TIMER_W-1:0]     up_reg;
  logic [TIMER_W-1:0]     up_next;
  // edge strobes
  logic                   sel_fall;
  logic                   sel_rise;
  logic                   sclk_fall;
  logic                   sclk_rise;

  function automatic logic went_low(input logic was_level,
                                    input logic now_level);
    went_low = was_level & ~now_level;
  endfunction : went_low

  function automatic logic went_high(input logic was_level,
                                     input logic now_level);
    went_high = ~was_level & now_level;
  endfunction : went_high

  // count lies in [lo, hi)
  function automatic logic in_window(input logic [CNT_W-1:0] cnt,
                                     input int               lo,
                                     input int               hi);
    in_window = (cnt >= CNT_W'(lo)) && (cnt < CNT_W'(hi));
  endfunction : in_window

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      sel_s1_reg <= 1'b1;
      sel_s2_reg <= 1'b1;
      sel_d_reg  <= 1'b1;
      clk_s1_reg <= 1'b1;
      clk_s2_reg <= 1'b1;
      clk_d_reg  <= 1'b1;
    end else begin
      sel_s1_reg <= LINK.sel_n;
      sel_s2_reg <= sel_s1_reg;
      sel_d_reg  <= sel_s2_reg;
      clk_s1_reg <= LINK.sclk;
      clk_s2_reg <= clk_s1_reg;
      clk_d_reg  <= clk_s2_reg;
    end
  end

  // clock edges count only while selected
  assign sel_fall  = went_low(sel_d_reg, sel_s2_reg);
  assign sel_rise  = went_high(sel_d_reg, sel_s2_reg);
  assign sclk_fall = went_low(clk_d_reg, clk_s2_reg) & ~sel_s2_reg;
  assign sclk_rise = went_high(clk_d_reg, clk_s2_reg) & ~sel_s2_reg;

  always_comb begin
    active_next = active_reg;
    cnt_next    = cnt_reg;
    shift_next  = shift_reg;
    oe_next     = oe_reg;
    track_next  = track_reg;
    pd_next     = pd_reg;
    waking_next = waking_reg;
    held_next   = held_reg;
    up_next     = up_reg;
    if (!pd_reg && up_reg != '0) begin
      up_next = up_reg - TIMER_W'(1);
    end
    if (sel_fall) begin
      active_next = 1'b1;
      cnt_next    = '0;
      oe_next     = 1'b1;
      track_next  = 1'b0;
      held_next   = SAMPLE_IN;
      shift_next  = {LEAD_ZEROS'(0), SAMPLE_IN};
      waking_next = pd_reg;
      // a dummy frame starts the analog side waking
      if (pd_reg) begin
        pd_next = 1'b0;
        up_next = TIMER_W'(POWER_UP_CYCLES);
      end
    end else if (active_reg && sel_rise) begin
      active_next = 1'b0;
      oe_next     = 1'b0;
      // decide the mode from the edges seen
      if (waking_reg) begin
        if (in_window(cnt_reg, 0, STAY_UP_EDGES)) begin
          pd_next = 1'b1;
        end
      end else if (in_window(cnt_reg, PD_LOW_EDGES, STAY_UP_EDGES)) begin
        pd_next = 1'b1;
      end
      // hold stays on while the analog side sleeps
      track_next  = ~pd_next;
      waking_next = 1'b0;
    end else if (active_reg) begin
      if (sclk_fall && cnt_reg < CNT_W'(FRAME_EDGES)) begin
        cnt_next   = cnt_reg + CNT_W'(1);
        shift_next = {shift_reg[FRAME_EDGES-2:0], 1'b0};
        if (cnt_reg == CNT_W'(FRAME_EDGES - 1)) begin
          oe_next = 1'b0;
        end
      end
      // waking: the first clock edge of either sense ends the hold
      if ((sclk_rise || sclk_fall) && waking_reg) begin
        track_next = 1'b1;
      end
      if (sclk_rise && in_window(cnt_reg, HOLD_EDGES, FRAME_EDGES + 1)) begin
        track_next = 1'b1;
      end
    end
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      active_reg <= 1'b0;
      cnt_reg    <= '0;
      shift_reg  <= '0;
      oe_reg     <= 1'b0;
      track_reg  <= 1'b1;
      pd_reg     <= 1'b0;
      waking_reg <= 1'b0;
      held_reg   <= '0;
      up_reg     <= '0;
    end else begin
      active_reg <= active_next;
      cnt_reg    <= cnt_next;
      shift_reg  <= shift_next;
      oe_reg     <= oe_next;
      track_reg  <= track_next;
      pd_reg     <= pd_next;
      waking_reg <= waking_next;
      held_reg   <= held_next;
      up_reg     <= up_next;
    end
  end

  // link pins and user outputs
  assign LINK.sdo_o   = shift_reg[FRAME_EDGES-1];
  assign LINK.sdo_oe  = oe_reg;
  assign SAMPLE_HELD  = held_reg;
  assign TRACKING     = track_reg;
  assign POWERED_DOWN = pd_reg;
  assign POWERED_UP   = ~pd_reg & (up_reg == '0);
endmodule : adc_device_end
`default_nettype wire

// ===== adc_host_end.sv
`timescale 1ns/10ps
`default_nettype none
module adc_host_end
  import adc_link_pkg::*;
(
  // clock and reset
  input  wire logic                   CLK,
  input  wire logic                   SYS_RST,
  // link
  adc_link_if.host                    LINK,
  // request: edges to clock in a frame (16 full, 10 abort/wake, 2..9 down)
  input  wire logic                   START,
  input  wire logic [CNT_W-1:0]       EDGES,
  output logic                        READY,
  // answer
  output logic      [RESULT_BITS-1:0] RESULT,
  output logic                        RESULT_VALID
);
  typedef enum logic [3:0] {
    S_IDLE  = 4'b0001,
    S_LEAD  = 4'b0010,
    S_CLOCK = 4'b0100,
    S_QUIET = 4'b1000
  } host_state_t;

  host_state_t             state_reg, state_next;
  logic                    sel_reg, sel_next;
  logic                    sclk_reg, sclk_next;
  logic [TIMER_W-1:0]      div_reg, div_next;
  logic [CNT_W-1:0]        cnt_reg, cnt_next;
  logic [CNT_W-1:0]        target_reg, target_next;
  logic [FRAME_EDGES-1:0]  rx_reg, rx_next;
  logic [RESULT_BITS-1:0]  res_reg, res_next;
  logic                    val_reg, val_next;
  logic                    sdo_s1_reg, sdo_s2_reg;

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      sdo_s1_reg <= 1'b1;
      sdo_s2_reg <= 1'b1;
    end else begin
      sdo_s1_reg <= LINK.sdo;
      sdo_s2_reg <= sdo_s1_reg;
    end
  end

  always_comb begin
    state_next  = state_reg;
    sel_next    = sel_reg;
    sclk_next   = sclk_reg;
    div_next    = div_reg;
    cnt_next    = cnt_reg;
    target_next = target_reg;
    rx_next     = rx_reg;
    res_next    = res_reg;
    val_next    = 1'b0;
    case (state_reg)
      S_IDLE: begin
        if (START) begin
          sel_next    = 1'b0;
          target_next = EDGES;
          cnt_next    = '0;
          div_next    = TIMER_W'(SCLK_HALF);
          state_next  = S_LEAD;
        end
      end
      S_LEAD, S_CLOCK: begin
        if (div_reg != '0) begin
          div_next = div_reg - TIMER_W'(1);
        end else begin
          div_next  = TIMER_W'(SCLK_HALF);
          sclk_next = ~sclk_reg;
          if (sclk_reg) begin
            rx_next  = {rx_reg[FRAME_EDGES-2:0], sdo_s2_reg};
            cnt_next = cnt_reg + CNT_W'(1);
            if (cnt_reg + CNT_W'(1) == target_reg) begin
              state_next = S_CLOCK;
            end
          end else if (state_reg == S_CLOCK) begin
            sel_next   = 1'b1;
            sclk_next  = 1'b1;
            div_next   = TIMER_W'(ACQ_CYC + QUIET_CYC
                                  + SCLK_HALF);
            state_next = S_QUIET;
            if (target_reg == CNT_W'(FRAME_EDGES)) begin
              res_next = rx_reg[RESULT_BITS-1:0];
              val_next = 1'b1;
            end
          end
        end
      end
      S_QUIET: begin
        if (div_reg != '0) begin
          div_next = div_reg - TIMER_W'(1);
        end else begin
          state_next = S_IDLE;
        end
      end
      default: begin
        state_next = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      state_reg  <= S_IDLE;
      sel_reg    <= 1'b1;
      sclk_reg   <= 1'b1;
      div_reg    <= '0;
      cnt_reg    <= '0;
      target_reg <= '0;
      rx_reg     <= '0;
      res_reg    <= '0;
      val_reg    <= 1'b0;
    end else begin
      state_reg  <= state_next;
      sel_reg    <= sel_next;
      sclk_reg   <= sclk_next;
      div_reg    <= div_next;
      cnt_reg    <= cnt_next;
      target_reg <= target_next;
      rx_reg     <= rx_next;
      res_reg    <= res_next;
      val_reg    <= val_next;
    end
  end

  assign LINK.sel_n   = sel_reg;
  assign LINK.sclk    = sclk_reg;
  assign READY        = (state_reg == S_IDLE);
  assign RESULT       = res_reg;
  assign RESULT_VALID = val_reg;
endmodule : adc_host_end
`default_nettype wire

// ===== adc_link_sva.sv
`timescale 1ns/10ps
`default_nettype none
module adc_link_sva
  import adc_link_pkg::*;
(
  // clock and reset
  input wire logic CLK,
  input wire logic SYS_RST,
  // link
  input wire logic sel_n,
  input wire logic sclk,
  input wire logic sdo_o,
  input wire logic sdo_oe,
  input wire logic sdo
);
  logic [CNT_W-1:0] cnt_reg, cnt_next;
  logic             sclk_reg;
  // falling edges seen in the current frame
  always_comb begin
    cnt_next = cnt_reg;
    if (sel_n) cnt_next = '0;
    else if (sclk_reg && !sclk && cnt_reg < 5'h10) cnt_next = cnt_reg + 5'h01;
  end
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      cnt_reg <= '0;
      sclk_reg <= 1'b1;
    end else begin
      cnt_reg <= cnt_next;
      sclk_reg <= sclk;
    end
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  a_drive_on_select: assert property ($fell(sel_n) ##1 (!sel_n)[*3] |-> ##[0:2] sdo_oe)
    else $error("output not driven after select fall");
  a_first_zero: assert property ($rose(sdo_oe) |-> !sdo_o && !sdo)
    else $error("first bit not zero");
  a_leading_zeros: assert property ($fell(sclk) && !sel_n && sdo_oe && cnt_reg < 5'h04 |-> !sdo_o)
    else $error("leading bit not zero");
  a_release_sixteen: assert property ($fell(sclk) && !sel_n && cnt_reg == 5'h0F |-> ##[1:5] !sdo_oe)
    else $error("output held after sixteenth edge");
  a_release_on_rise: assert property ($rose(sel_n) |-> ##[1:4] !sdo_oe)
    else $error("output held after select rise");
  a_idle_floats: assert property (sel_n[*6] |-> !sdo_oe)
    else $error("output driven while idle");
  a_oe_steady: assert property ($fell(sdo_oe) |-> sel_n || cnt_reg == 5'h10)
    else $error("output released inside frame");
  a_quiet_gap: assert property ($rose(sel_n) |=> sel_n[*2])
    else $error("select fell too soon");
  c_full: cover property ($fell(sclk) && !sel_n && cnt_reg == 5'h0F);
  c_down: cover property ($rose(sel_n) && cnt_reg > 5'h01 && cnt_reg < 5'h0A);
  c_abort: cover property ($rose(sel_n) && cnt_reg > 5'h09 && cnt_reg < 5'h10);
endmodule : adc_link_sva
`default_nettype wire

// ===== testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench
  import adc_link_pkg::*;
;
  localparam int PU = 2;
  logic                   CLK = 1'b0;
  logic                   SYS_RST = 1'b1;
  logic                   START = 1'b0;
  logic [CNT_W-1:0]       EDGES = '0;
  logic [RESULT_BITS-1:0] SAMPLE_IN = '0;
  logic [RESULT_BITS-1:0] sample_held, result, got;
  logic                   tracking, powered_down, powered_up;
  logic                   ready, result_valid, trk, trk_end;
  logic                   sel_q = 1'b1;
  int                     n_mismatch = 0;
  int                     num_checks = 0;
  int                     n_valid = 0;
  adc_link_if link ();
  adc_device_end #(.POWER_UP_CYCLES(PU)) adc_device_end_inst (.CLK(CLK),
    .SYS_RST(SYS_RST), .LINK(link.device), .SAMPLE_IN(SAMPLE_IN),
    .SAMPLE_HELD(sample_held), .TRACKING(tracking),
    .POWERED_DOWN(powered_down), .POWERED_UP(powered_up));
  adc_host_end adc_host_end_inst (.CLK(CLK), .SYS_RST(SYS_RST),
    .LINK(link.host), .START(START), .EDGES(EDGES), .READY(ready),
    .RESULT(result), .RESULT_VALID(result_valid));
  adc_link_sva adc_link_sva_inst (.CLK(CLK), .SYS_RST(SYS_RST),
    .sel_n(link.sel_n), .sclk(link.sclk), .sdo_o(link.sdo_o),
    .sdo_oe(link.sdo_oe), .sdo(link.sdo));
  always #50 CLK = ~CLK;
  always @(posedge CLK) begin
    sel_q <= link.sel_n;
    if (sel_q === 1'b0 && link.sel_n === 1'b1) begin
      trk_end <= tracking;
    end
    if (result_valid === 1'b1) begin
      got <= result;
      n_valid <= n_valid + 1;
    end
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic frame(input int e, input logic [RESULT_BITS-1:0] s);
    int i;
    @(posedge CLK);
    START <= 1'b1;
    EDGES <= CNT_W'(e);
    SAMPLE_IN <= s;
    @(posedge CLK);
    START <= 1'b0;
    for (i = 0; i < 8 && link.sel_n !== 1'b0; i++) @(posedge CLK);
    repeat (10) @(posedge CLK);
    trk = tracking;
    for (i = 0; i < 600 && ready !== 1'b1; i++) @(posedge CLK);
    repeat (2) @(posedge CLK);
    #1;
  endtask : frame
  task automatic t_full();
    logic [RESULT_BITS-1:0] v [3] = '{12'hA5C, 12'h801, 12'h7FE};
    int nv;
    foreach (v[k]) begin
      nv = n_valid;
      frame(16, v[k]);
      check(16'(n_valid), 16'(nv + 1));
      check(got, v[k]);
      check(sample_held, v[k]);
      check(trk, 0);
      check(trk_end, 1);
      check(powered_down, 0);
    end
    $display("done full frames");
  endtask : t_full
  task automatic t_short();
    int e [3] = '{1, 12, 15};
    int nv;
    foreach (e[k]) begin
      nv = n_valid;
      frame(e[k], 12'h0F0);
      check(16'(n_valid), 16'(nv));
      check(powered_down, 0);
      check(trk_end, 16'(e[k] > HOLD_EDGES));
    end
    $display("done short frames");
  endtask : t_short
  task automatic t_down();
    for (int e = 2; e < 10; e++) begin
      frame(e, 12'h000);
      check(powered_down, 1);
      check(tracking, 0);
      frame(8, 12'h000);
      check(powered_down, 1);
      check(trk, 1);
      check(tracking, 0);
      frame(10, 12'h000);
      check(powered_down, 0);
      repeat (PU + 2) @(posedge CLK);
      check(powered_up, 1);
    end
    $display("done power down");
  endtask : t_down
  task automatic t_reset();
    frame(5, 12'h000);
    START <= 1'b1;
    EDGES <= 5'h10;
    repeat (40) @(posedge CLK);
    SYS_RST <= 1'b1;
    START <= 1'b0;
    repeat (2) @(posedge CLK);
    SYS_RST <= 1'b0;
    @(posedge CLK);
    #1;
    check(powered_down, 0);
    check(tracking, 1);
    check(powered_up, 1);
    check(ready, 1);
    check(link.sdo_oe, 0);
    $display("done reset");
  endtask : t_reset
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : test_done
  initial begin
    repeat (20) @(posedge CLK);
    SYS_RST <= 1'b0;
    frame(10, 12'h000);
    check(powered_down, 0);
    t_full();
    t_short();
    t_down();
    t_full();
    t_reset();
    t_full();
    test_done();
  end
  initial begin
    repeat (30000) @(posedge CLK);
    n_mismatch++;
    test_done();
  end
endmodule : testbench
`default_nettype wire
